//--- inc/rxpof_pkg.sv
package rxpof_pkg;

   // ========
   // strap levels and pin carrier
   // ========
   typedef enum logic [1:0] {
      RXPOF_LOW  = 2'b00,
      RXPOF_MID  = 2'b01,
      RXPOF_HIGH = 2'b10
   } rxpof_lvl_e;

   // sense pair of one three-level pin: above upper / below lower threshold
   typedef struct packed {
      logic above;
      logic below;
   } rxpof_strap_s;

   // decoded receive-side controls handed to the link domain
   typedef struct packed {
      rxpof_lvl_e dec;
      rxpof_lvl_e par;
      rxpof_lvl_e frm;
      rxpof_lvl_e cks;
   } rxpof_cfg_s;

   localparam int RXPOF_CHANNELS = 4;
   localparam int RXPOF_CHAR_W   = 10;
   localparam int RXPOF_DATA_W   = 8;
   localparam int RXPOF_STAT_W   = 3;
   localparam int RXPOF_NSTRAPS  = 9;

   // ========
   // register map (byte addresses)
   // ========
   localparam logic [3:0] RXPOF_ADDR_CTRL  = 4'h0;
   localparam logic [3:0] RXPOF_ADDR_STRAP = 4'h4;
   localparam logic [3:0] RXPOF_ADDR_MODE  = 4'h8;
   localparam logic [3:0] RXPOF_ADDR_FRAME = 4'hC;

   // control register fields
   localparam int RXPOF_CTRL_OVR   = 0;
   localparam int RXPOF_CTRL_DEC   = 2;
   localparam int RXPOF_CTRL_PAR   = 4;
   localparam int RXPOF_CTRL_FRM   = 6;
   localparam int RXPOF_CTRL_CKS   = 8;
   localparam logic [9:0] RXPOF_CTRL_RESET = 10'h155;
   localparam logic [9:0] RXPOF_CTRL_MASK  = 10'h3FD;

   localparam logic [1:0] RXPOF_RESP_OKAY   = 2'b00;
   localparam logic [1:0] RXPOF_RESP_SLVERR = 2'b10;

   // ========
   // framing patterns, a-bit in the msb
   // ========
   localparam logic [7:0] RXPOF_COMMA8_NEG = 8'h3E;
   localparam logic [7:0] RXPOF_COMMA8_POS = 8'hC1;
   localparam logic [9:0] RXPOF_K285_NEG   = 10'h0FA;
   localparam logic [9:0] RXPOF_K285_POS   = 10'h305;

endpackage : rxpof_pkg

//--- logic/rxpof_ctrl.sv
// What this block does
// - three-level straps decode; open pin reads MID
// - tx mode strap pair gives one of nine
// - data and status change on interface clock rise
// - decoder on: decoded data and status out
// - decoder bypassed: char bits 9..2 on data
// - bypass: low bits on status, bit2 flags comma
// - parity valid unless strap LOW, else high-Z
// - full rate: one clock rise per character
// - half rate: alternate rises on true, complement
// - reference clocking ignores rate; A,C follow it
// - framer seeks 8-bit comma or K28.5 forms
// - reframe enable lets all framers realign
// - rx mode strap pair gives one of nine
// - clock source LOW reference, MID recovered clocks
`timescale 1ns/1ps
`default_nettype none

module rxpof_ctrl
   import rxpof_pkg::*;
(
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic                         clk_en,
   input  wire logic [3:0]                   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output var  logic                         s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output var  logic                         s_axi_wready,
   output var  logic [1:0]                   s_axi_bresp,
   output var  logic                         s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [3:0]                   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output var  logic                         s_axi_arready,
   output var  logic [31:0]                  s_axi_rdata,
   output var  logic [1:0]                   s_axi_rresp,
   output var  logic                         s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   input  wire rxpof_strap_s [1:0]           tx_op_mode_strap,
   input  wire rxpof_strap_s [1:0]           rx_op_mode_strap,
   input  wire rxpof_strap_s                 decoder_mode_strap,
   input  wire rxpof_strap_s                 parity_ctrl_strap,
   input  wire rxpof_strap_s                 frame_char_strap,
   input  wire rxpof_strap_s                 rx_clk_source_strap,
   input  wire rxpof_strap_s                 reframe_mode_strap,
   output var  logic [3:0]                   tx_op_mode,
   output var  logic [3:0]                   rx_op_mode,
   input  wire logic                         link_clk,
   input  wire logic                         rx_clk_half_rate_sel,
   input  wire logic                         reframe_enable,
   input  wire logic                         rx_word_valid,
   input  wire logic [3:0][9:0]              rx_word,
   input  wire logic [3:0][7:0]              rx_dec_char,
   input  wire logic [3:0][2:0]              rx_dec_status,
   output var  logic [3:0][9:0]              rx_framed_char,
   output var  logic [3:0][7:0]              rx_char_out,
   output var  logic [3:0][2:0]              rx_char_status,
   output var  logic [3:0]                   rx_odd_parity_out,
   output var  logic [3:0]                   rx_odd_parity_oe_n,
   output var  logic [3:0]                   rx_iface_clk_out,
   output var  logic [3:0]                   rx_iface_clk_out_n,
   output var  logic [3:0]                   rx_iface_clk_oe_n
);

   // ========
   // helper functions
   // ========
   // open or inconsistent pin self-biases to the middle level
   function automatic rxpof_lvl_e lvl_of(input rxpof_strap_s p);
      rxpof_lvl_e l;
      l = RXPOF_MID;
      if (p.above && !p.below) begin
         l = RXPOF_HIGH;
      end else if (p.below && !p.above) begin
         l = RXPOF_LOW;
      end
      return l;
   endfunction : lvl_of

   // two ternary digits give an index 0..8
   function automatic logic [3:0] mode_of(input rxpof_lvl_e hi, input rxpof_lvl_e lo);
      logic [3:0] h;
      logic [3:0] l;
      h = {2'b00, hi};
      l = {2'b00, lo};
      return 4'((h << 1) + h + l);
   endfunction : mode_of

   // ========
   // strap pins: two flops, then decode
   // ========
   localparam int SW = 2 * RXPOF_NSTRAPS;
   logic [SW-1:0] strap_raw;
   logic [SW-1:0] strap_m_q;
   logic [SW-1:0] strap_s_q;

   assign strap_raw = {tx_op_mode_strap, rx_op_mode_strap, decoder_mode_strap,
                       parity_ctrl_strap, frame_char_strap, rx_clk_source_strap,
                       reframe_mode_strap};

   // strap synchroniser
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strap_m_q <= '0;
         strap_s_q <= '0;
      end else if (clk_en) begin
         strap_m_q <= strap_raw;
         strap_s_q <= strap_m_q;
      end
   end

   rxpof_lvl_e [RXPOF_NSTRAPS-1:0] lvl;

   genvar gs;
   generate
      for (gs = 0; gs < RXPOF_NSTRAPS; gs++) begin : g_strap
         assign lvl[gs] = lvl_of(rxpof_strap_s'(strap_s_q[2*gs +: 2]));
      end
   endgenerate

   // strap order: 8,7 tx; 6,5 rx; 4 dec; 3 par; 2 frm; 1 cks; 0 reframe mode
   logic [9:0] ctrl_q;
   rxpof_cfg_s strap_cfg;
   rxpof_cfg_s reg_cfg;
   rxpof_cfg_s eff_cfg;

   assign strap_cfg = '{dec: lvl[4], par: lvl[3], frm: lvl[2], cks: lvl[1]};
   assign reg_cfg   = '{dec: rxpof_lvl_e'(ctrl_q[RXPOF_CTRL_DEC +: 2]),
                        par: rxpof_lvl_e'(ctrl_q[RXPOF_CTRL_PAR +: 2]),
                        frm: rxpof_lvl_e'(ctrl_q[RXPOF_CTRL_FRM +: 2]),
                        cks: rxpof_lvl_e'(ctrl_q[RXPOF_CTRL_CKS +: 2])};
   assign eff_cfg   = ctrl_q[RXPOF_CTRL_OVR] ? reg_cfg : strap_cfg;

   // mode indices
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_op_mode <= 4'h0;
         rx_op_mode <= 4'h0;
      end else if (clk_en) begin
         tx_op_mode <= mode_of(lvl[8], lvl[7]);
         rx_op_mode <= mode_of(lvl[6], lvl[5]);
      end
   end

   // ========
   // axi4-lite slave
   // ========
   logic [3:0]  aw_addr_q;
   logic        aw_hold_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        w_hold_q;
   logic [3:0]  frame_s_q;
   logic        aw_take, w_take, ar_take, do_write, aw_hold_d, w_hold_d;
   logic        bvalid_d, rvalid_d, wr_ctrl, rd_hit, wr_hit;
   logic [31:0] ctrl_wr_val;
   logic [31:0] rd_val;
   logic [31:0] ctrl_ext;

   assign aw_take   = s_axi_awvalid & s_axi_awready;
   assign w_take    = s_axi_wvalid & s_axi_wready;
   assign ar_take   = s_axi_arvalid & s_axi_arready;
   assign do_write  = aw_hold_q & w_hold_q & ~s_axi_bvalid;
   assign aw_hold_d = (aw_hold_q | aw_take) & ~do_write;
   assign w_hold_d  = (w_hold_q | w_take) & ~do_write;
   assign bvalid_d  = do_write | (s_axi_bvalid & ~s_axi_bready);
   assign rvalid_d  = ar_take | (s_axi_rvalid & ~s_axi_rready);
   assign wr_hit    = (aw_addr_q == RXPOF_ADDR_CTRL);
   assign wr_ctrl   = do_write & wr_hit;
   assign ctrl_ext  = {22'h0, ctrl_q};

   // byte lanes applied to the control word
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_lane
         assign ctrl_wr_val[8*gb +: 8] = w_strb_q[gb] ? w_data_q[8*gb +: 8]
                                                      : ctrl_ext[8*gb +: 8];
      end
   endgenerate

   // read decode
   assign rd_hit = (s_axi_araddr == RXPOF_ADDR_CTRL) || (s_axi_araddr == RXPOF_ADDR_STRAP)
                || (s_axi_araddr == RXPOF_ADDR_MODE) || (s_axi_araddr == RXPOF_ADDR_FRAME);
   assign rd_val = (s_axi_araddr == RXPOF_ADDR_CTRL)  ? ctrl_ext :
                   (s_axi_araddr == RXPOF_ADDR_STRAP) ? {14'h0, lvl} :
                   (s_axi_araddr == RXPOF_ADDR_MODE)  ? {24'h0, rx_op_mode, tx_op_mode} :
                   (s_axi_araddr == RXPOF_ADDR_FRAME) ? {28'h0, frame_s_q} : 32'h0;

   // write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q     <= 1'b0;
         w_hold_q      <= 1'b0;
         aw_addr_q     <= 4'h0;
         w_data_q      <= 32'h0;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RXPOF_RESP_OKAY;
      end else if (clk_en) begin
         aw_hold_q     <= aw_hold_d;
         w_hold_q      <= w_hold_d;
         if (aw_take) aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
         if (w_take) w_data_q <= s_axi_wdata;
         if (w_take) w_strb_q <= s_axi_wstrb;
         s_axi_awready <= ~aw_hold_d & ~bvalid_d;
         s_axi_wready  <= ~w_hold_d & ~bvalid_d;
         s_axi_bvalid  <= bvalid_d;
         if (do_write) s_axi_bresp <= wr_hit ? RXPOF_RESP_OKAY : RXPOF_RESP_SLVERR;
      end
   end

   // control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= RXPOF_CTRL_RESET;
      end else if (clk_en && wr_ctrl) begin
         ctrl_q <= ctrl_wr_val[9:0] & RXPOF_CTRL_MASK;
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= RXPOF_RESP_OKAY;
      end else if (clk_en) begin
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid  <= rvalid_d;
         if (ar_take) s_axi_rdata <= rd_val;
         if (ar_take) s_axi_rresp <= rd_hit ? RXPOF_RESP_OKAY : RXPOF_RESP_SLVERR;
      end
   end

   // ========
   // crossings into the link domain
   // ========
   logic [2:0] lrst_q;
   logic [1:0] lce_q;
   logic [1:0] rf_q;
   logic [1:0] half_q;
   rxpof_cfg_s cfg_m_q;
   rxpof_cfg_s cfg_q;
   logic       lrun;

   assign lrun = lrst_q[2] & lce_q[1];

   // reset three flops; enable, pins and quasi-static config, two flops each
   always_ff @(posedge link_clk) begin
      lrst_q  <= {lrst_q[1:0], aresetn};
      lce_q   <= {lce_q[0], clk_en};
      rf_q    <= {rf_q[0], reframe_enable};
      half_q  <= {half_q[0], rx_clk_half_rate_sel};
      cfg_m_q <= eff_cfg;
      cfg_q   <= cfg_m_q;
   end

   logic       ref_mode;
   logic       bypass;
   logic       rf_ok;
   logic       half_rate;
   assign ref_mode  = (cfg_q.cks == RXPOF_LOW);
   assign bypass    = (cfg_q.dec == RXPOF_LOW);
   assign rf_ok     = rf_q[1];
   assign half_rate = half_q[1] & ~ref_mode;

   // ========
   // per-channel framer and output register
   // ========
   logic [3:0] framed_q;

   genvar gc;
   generate
      for (gc = 0; gc < RXPOF_CHANNELS; gc++) begin : g_ch
         logic [9:0]  prev_q;
         logic [3:0]  align_q;
         logic [19:0] win;
         logic [19:0] win_sh;
         logic [9:0]  hit;
         logic        found, comma, load, clk_d;
         logic [3:0]  hit_idx;
         logic [3:0]  use_idx;
         logic [9:0]  char_now;
         logic [7:0]  data_d;
         logic [2:0]  stat_d;

         assign win = {prev_q, rx_word[gc]};

         // pattern search over every bit offset
         for (genvar k = 0; k < 10; k++) begin : g_off
            logic [9:0] cand;
            assign cand   = win[19-k -: 10];
            assign hit[k] = (cfg_q.frm == RXPOF_MID)
                            ? (cand[9:2] == RXPOF_COMMA8_NEG || cand[9:2] == RXPOF_COMMA8_POS)
                            : (cfg_q.frm == RXPOF_HIGH)
                            ? (cand == RXPOF_K285_NEG || cand == RXPOF_K285_POS)
                            : 1'b0;
         end

         // lowest matching offset wins
         always_comb begin
            found   = 1'b0;
            hit_idx = 4'h0;
            for (int k = 9; k >= 0; k--) begin
               if (hit[k]) begin
                  found   = 1'b1;
                  hit_idx = 4'(k);
               end
            end
         end

         assign use_idx  = (rf_ok && found) ? hit_idx : align_q;
         assign win_sh   = win << use_idx;
         assign char_now = win_sh[19:10];
         assign comma    = (char_now[9:2] == RXPOF_COMMA8_NEG)
                        || (char_now[9:2] == RXPOF_COMMA8_POS);
         assign load     = lrun & rx_word_valid;

         // data and status selection
         assign data_d = bypass ? char_now[9:2] : rx_dec_char[gc];
         assign stat_d = bypass ? {comma, char_now[1:0]} : rx_dec_status[gc];

         // interface clock: pulse per char, toggle per char at half rate
         assign clk_d = ref_mode ? ~rx_iface_clk_out[gc] :
                        load ? (half_rate ? ~rx_iface_clk_out[gc] : 1'b1) :
                        (half_rate ? rx_iface_clk_out[gc] : 1'b0);

         // framer state
         always_ff @(posedge link_clk) begin
            if (!lrst_q[2]) begin
               prev_q       <= 10'h0;
               align_q      <= 4'h0;
               framed_q[gc] <= 1'b0;
            end else if (load) begin
               prev_q  <= rx_word[gc];
               align_q <= use_idx;
               if (rf_ok && found) framed_q[gc] <= 1'b1;
            end
         end

         // output register, changes with the clock rise
         always_ff @(posedge link_clk) begin
            if (!lrst_q[2]) begin
               rx_char_out[gc]        <= 8'h0;
               rx_char_status[gc]     <= 3'h0;
               rx_odd_parity_out[gc]  <= 1'b1;
               rx_framed_char[gc]     <= 10'h0;
            end else if (load) begin
               rx_char_out[gc]        <= data_d;
               rx_char_status[gc]     <= stat_d;
               rx_odd_parity_out[gc]  <= ~^data_d;
               rx_framed_char[gc]     <= char_now;
            end
         end

         // clock pins and enables
         always_ff @(posedge link_clk) begin
            if (!lrst_q[2]) begin
               rx_iface_clk_out[gc]   <= 1'b0;
               rx_iface_clk_out_n[gc] <= 1'b1;
               rx_iface_clk_oe_n[gc]  <= 1'b1;
               rx_odd_parity_oe_n[gc] <= 1'b1;
            end else if (lce_q[1]) begin
               rx_iface_clk_out[gc]   <= clk_d;
               rx_iface_clk_out_n[gc] <= ~clk_d;
               rx_iface_clk_oe_n[gc]  <= ref_mode && (gc % 2 == 1);
               rx_odd_parity_oe_n[gc] <= (cfg_q.par == RXPOF_LOW);
            end
         end
      end
   endgenerate

   // framed flags back to the register side
   logic [3:0] frame_m_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_m_q <= 4'h0;
         frame_s_q <= 4'h0;
      end else if (clk_en) begin
         frame_m_q <= framed_q;
         frame_s_q <= frame_m_q;
      end
   end

endmodule : rxpof_ctrl

`default_nettype wire

//--- verification/rxpof_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// link output checker
// ========
module rxpof_monitor
   import rxpof_pkg::*;
(
   input wire logic            aclk,
   input wire logic            aresetn,
   input wire logic            clk_en,
   input wire logic            link_clk,
   input wire logic            rx_clk_half_rate_sel,
   input wire logic [3:0]      tx_op_mode,
   input wire logic [3:0]      rx_op_mode,
   input wire logic [3:0][9:0] rx_framed_char,
   input wire logic [3:0][7:0] rx_char_out,
   input wire logic [3:0][2:0] rx_char_status,
   input wire logic [3:0]      rx_odd_parity_out,
   input wire logic [3:0]      rx_odd_parity_oe_n,
   input wire logic [3:0]      rx_iface_clk_out,
   input wire logic [3:0]      rx_iface_clk_out_n,
   input wire logic [3:0]      rx_iface_clk_oe_n
);
   logic [2:0] cnt_q;
   logic [3:0] pok;
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!aresetn);
   // cycles since rate or clock mode last moved
   always_ff @(posedge link_clk) begin
      if (!aresetn || !clk_en || $changed(rx_clk_half_rate_sel) ||
          $changed(rx_iface_clk_oe_n[1]))
         cnt_q <= 3'h0;
      else if (cnt_q != 3'h7)
         cnt_q <= cnt_q + 3'h1;
   end
   // odd count per driven channel
   always_comb begin
      for (int i = 0; i < 4; i++)
         pok[i] = rx_odd_parity_oe_n[i] | ^{rx_char_out[i], rx_odd_parity_out[i]};
   end
   property p_par_odd;
      &pok;
   endproperty
   a_par_odd: assert property (p_par_odd) else $error("parity not odd");
   property p_clk_comp;
      ((rx_iface_clk_out ^ rx_iface_clk_out_n) | rx_iface_clk_oe_n) == 4'hF;
   endproperty
   a_clk_comp: assert property (p_clk_comp) else $error("clock pair");
   property p_data_on_clk;
      $changed(rx_char_out) |-> $changed(rx_iface_clk_out[0]);
   endproperty
   a_data_on_clk: assert property (p_data_on_clk) else $error("data off clock");
   property p_full_rate;
      cnt_q == 3'h7 && !rx_clk_half_rate_sel && !rx_iface_clk_oe_n[1] &&
         $rose(rx_iface_clk_out[0]) |=> $fell(rx_iface_clk_out[0]);
   endproperty
   a_full_rate: assert property (p_full_rate) else $error("full rate pulse");
   property p_half_rate;
      cnt_q == 3'h7 && rx_clk_half_rate_sel && !rx_iface_clk_oe_n[1] &&
         $rose(rx_iface_clk_out[0]) |=> rx_iface_clk_out[0];
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("half rate level");
   property p_ref_follow;
      cnt_q == 3'h7 && rx_iface_clk_oe_n[1] && !rx_iface_clk_oe_n[0] |->
         $changed(rx_iface_clk_out[0]) && $changed(rx_iface_clk_out[2]);
   endproperty
   a_ref_follow: assert property (p_ref_follow) else $error("ref clock");
   property p_ref_oe;
      cnt_q == 3'h7 && rx_iface_clk_oe_n[1] |->
         rx_iface_clk_oe_n[3] && !rx_iface_clk_oe_n[0] && !rx_iface_clk_oe_n[2];
   endproperty
   a_ref_oe: assert property (p_ref_oe) else $error("clock enables");
   property p_comma_flag;
      rx_char_out[0] == rx_framed_char[0][9:2] |-> rx_char_status[0] ==
         {rx_char_out[0] == RXPOF_COMMA8_NEG || rx_char_out[0] == RXPOF_COMMA8_POS,
          rx_framed_char[0][1:0]};
   endproperty
   a_comma_flag: assert property (p_comma_flag) else $error("bypass status");
   property p_mode_range;
      @(posedge aclk) disable iff (!aresetn) tx_op_mode <= 4'h8 && rx_op_mode <= 4'h8;
   endproperty
   a_mode_range: assert property (p_mode_range) else $error("mode index");
   c_half: cover property (rx_clk_half_rate_sel && $rose(rx_iface_clk_out_n[0]));
   c_ref: cover property (rx_iface_clk_oe_n[1] && !rx_iface_clk_oe_n[0]);
   c_comma: cover property (rx_char_status[0][2]);
endmodule : rxpof_monitor
bind rxpof_ctrl rxpof_monitor u_mon (.*);
`default_nettype wire

//--- verification/rxpof_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// host latch on interface clock
// ========
module rxpof_host_model
   import rxpof_pkg::*;
(
   input  wire logic       link_clk,
   input  wire logic       half,
   input  wire logic       ck,
   input  wire logic       ck_n,
   input  wire logic [7:0] d,
   input  wire logic [2:0] st,
   output var  logic [7:0] cap_d,
   output var  logic [2:0] cap_st,
   output var  int         cap_cnt
);
   logic ck_q;
   logic ckn_q;
   initial begin
      cap_cnt = 0;
      ck_q    = 1'b0;
      ckn_q   = 1'b1;
   end
   // latch on true rise, also on complement rise at half rate
   always @(posedge link_clk) begin
      if ((ck && !ck_q) || (half && ck_n && !ckn_q)) begin
         cap_d   <= d;
         cap_st  <= st;
         cap_cnt <= cap_cnt + 1;
      end
      ck_q  <= ck;
      ckn_q <= ck_n;
   end
endmodule : rxpof_host_model
`default_nettype wire

//--- verification/tb_rxpof_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rxpof_ctrl
   import rxpof_pkg::*;
;
   logic               aclk, aresetn, clk_en, link_clk, rx_clk_half_rate_sel, reframe_enable;
   logic               rx_word_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic               s_axi_rvalid, s_axi_rready;
   logic [3:0]         s_axi_awaddr, s_axi_araddr, s_axi_wstrb, tx_op_mode, rx_op_mode;
   logic [31:0]        s_axi_wdata, s_axi_rdata, rd;
   logic [1:0]         s_axi_bresp, s_axi_rresp, rs;
   rxpof_strap_s [1:0] tx_op_mode_strap, rx_op_mode_strap;
   rxpof_strap_s       decoder_mode_strap, parity_ctrl_strap, frame_char_strap;
   rxpof_strap_s       rx_clk_source_strap, reframe_mode_strap;
   logic [3:0][9:0]    rx_word, rx_framed_char;
   logic [3:0][7:0]    rx_dec_char, rx_char_out;
   logic [3:0][2:0]    rx_dec_status, rx_char_status;
   logic [3:0]         rx_odd_parity_out, rx_odd_parity_oe_n, rx_iface_clk_out;
   logic [3:0]         rx_iface_clk_out_n, rx_iface_clk_oe_n;
   logic [7:0]         cap_d;
   logic [2:0]         cap_st;
   logic [9:0]         pw;
   int                 cap_cnt, bad_count, samples_checked;

   rxpof_ctrl uut (.*);
   rxpof_host_model u_host (.link_clk, .half(rx_clk_half_rate_sel), .ck(rx_iface_clk_out[0]),
      .ck_n(rx_iface_clk_out_n[0]), .d(rx_char_out[0]), .st(rx_char_status[0]),
      .cap_d, .cap_st, .cap_cnt);

   // ========
   // clocks, checks, bus cycles
   // ========
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      link_clk = 1'b0;
      #3;
      forever #7.5 link_clk = ~link_clk;
   end
   task end_sim;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task chk(input string n, input logic [39:0] e, input logic [39:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk
   function automatic rxpof_strap_s enc(input int l, input logic alt);
      return (l == 0) ? 2'b01 : (l == 2) ? 2'b10 : {alt, alt};
   endfunction : enc
   task axw(input logic [3:0] a, input logic [31:0] d);
      logic wa, wd, wb;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      {wa, wd, wb} = 3'h7;
      while (wb) begin
         @(posedge aclk);
         if (wa && s_axi_awready) begin
            wa = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (wd && s_axi_wready) begin
            wd = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
         if (!wa && !wd && s_axi_bvalid) wb = 1'b0;
      end
   endtask : axw
   task axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic wa, wb;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      {wa, wb} = 2'h3;
      while (wb) begin
         @(posedge aclk);
         if (!wa && s_axi_rvalid) begin
            wb = 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
         if (wa && s_axi_arready) begin
            wa = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
      end
   endtask : axr
   task cfg(input logic [9:0] v, input logic hr, input logic rf);
      @(posedge aclk);
      rx_clk_half_rate_sel <= hr;
      reframe_enable       <= rf;
      axw(RXPOF_ADDR_CTRL, {22'h0, v});
      repeat (20) @(posedge aclk);
   endtask : cfg
   // one character on all channels, line inverted once taken
   task word(input logic [9:0] w, input logic [7:0] dc, input logic [2:0] ds);
      @(posedge link_clk);
      rx_word       <= {4{w}};
      rx_dec_char   <= {4{dc}};
      rx_dec_status <= {4{ds}};
      rx_word_valid <= 1'b1;
      @(posedge link_clk);
      rx_word_valid <= 1'b0;
      rx_word       <= ~{4{w}};
      repeat (2) @(posedge link_clk);
   endtask : word
   task dec_run(input int n, input logic m);
      int c0;
      c0 = cap_cnt;
      for (int i = 0; i < n; i++) begin
         word(10'h000, 8'h10 + i[7:0], i[2:0]);
         chk("data", {4{8'h10 + i[7:0]}}, rx_char_out);
         chk("stat", {4{i[2:0]}}, rx_char_status);
         if (m) begin
            chk("host_data", 8'h10 + i[7:0], cap_d);
            chk("host_cnt", c0 + i + 1, cap_cnt);
         end
      end
   endtask : dec_run
   task stream(input int k, input logic [9:0] c, input int ke);
      logic [9:0]  ch [6];
      logic [19:0] pr;
      logic [9:0]  w, e;
      ch = '{10'h2AA, 10'h2AA, c, 10'h2AA, 10'h2AA, 10'h2AA};
      for (int n = 1; n < 6; n++) begin
         w  = 10'({ch[n-1], ch[n]} >> k);
         word(w, 8'h00, 3'h0);
         pr = {pw, w};
         e  = pr[19-ke -: 10];
         pw = w;
         if (n >= 3) begin
            chk("framed", {4{e}}, rx_framed_char);
            chk("data", {4{e[9:2]}}, rx_char_out);
            chk("stat", {4{e[9:2] == RXPOF_COMMA8_NEG || e[9:2] == RXPOF_COMMA8_POS,
                 e[1:0]}}, rx_char_status);
         end
      end
   endtask : stream

   // ========
   // test sequence
   // ========
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h05;
      {rx_clk_half_rate_sel, reframe_enable, rx_word_valid, bad_count, samples_checked} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_word, rx_dec_char, rx_dec_status} = '0;
      {tx_op_mode_strap, rx_op_mode_strap, decoder_mode_strap, parity_ctrl_strap} = '0;
      {frame_char_strap, rx_clk_source_strap, reframe_mode_strap, pw} = '0;
      clk_en      = 1'b1;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axr(RXPOF_ADDR_CTRL, rd, rs);
      chk("ctrl_rst", 32'h0000_0155, rd);
      axw(RXPOF_ADDR_CTRL, 32'h0000_0157);
      axr(RXPOF_ADDR_CTRL, rd, rs);
      chk("ctrl_rd", 32'h0000_0155, rd);
      axr(4'h2, rd, rs);
      chk("unmapped", {RXPOF_RESP_SLVERR, 32'h0}, {rs, rd});
      for (int i = 0; i < 9; i++) begin
         tx_op_mode_strap   <= {enc(i / 3, i[0]), enc(i % 3, 1'b0)};
         rx_op_mode_strap   <= {enc((8 - i) / 3, 1'b0), enc((8 - i) % 3, i[0])};
         {decoder_mode_strap, parity_ctrl_strap, frame_char_strap, rx_clk_source_strap,
          reframe_mode_strap} <= {5{enc(i % 3, i[0])}};
         repeat (8) @(posedge aclk);
         chk("tx_mode", i, tx_op_mode);
         chk("rx_mode", 8 - i, rx_op_mode);
         axr(RXPOF_ADDR_STRAP, rd, rs);
         chk("strap_lvl", {5{2'(i % 3)}}, rd[9:0]);
      end
      cfg(10'h185, 1'b0, 1'b0);
      chk("par_oe_off", 4'hF, rx_odd_parity_oe_n);
      dec_run(4, 1'b1);
      cfg(10'h185, 1'b1, 1'b0);
      dec_run(4, 1'b1);
      cfg(10'h0A5, 1'b1, 1'b0);
      chk("clk_oe_ref", 4'hA, rx_iface_clk_oe_n);
      chk("par_oe_on", 4'h0, rx_odd_parity_oe_n);
      dec_run(2, 1'b0);
      cfg(10'h191, 1'b0, 1'b1);
      stream(3, RXPOF_K285_NEG, 3);
      cfg(10'h191, 1'b0, 1'b0);
      stream(6, RXPOF_K285_NEG, 3);
      cfg(10'h151, 1'b0, 1'b1);
      stream(6, 10'h0F9, 6);
      cfg(10'h111, 1'b0, 1'b1);
      stream(2, RXPOF_K285_NEG, 6);
      end_sim();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      end_sim();
   end
endmodule : tb_rxpof_ctrl
`default_nettype wire
